// [pkg/css_consts.svh]
// Constants for the clock synchronous serial channel
`ifndef CSS_CONSTS_SVH
`define CSS_CONSTS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CSS_OFF_TXBUF  4'h0
`define CSS_OFF_RXBUF  4'h1
`define CSS_OFF_BAUD   4'h2
`define CSS_OFF_MODE   4'h3
`define CSS_OFF_CTRL0  4'h4
`define CSS_OFF_CTRL1  4'h5
`define CSS_OFF_PRESC  4'h6
`define CSS_OFF_OPT    4'h7
// ----------------------------------------
// Field positions
// ----------------------------------------
`define CSS_MODE_SMD_LO   0
`define CSS_MODE_CLOCK_SOURCE_DIR    3
`define CSS_C0_SRC_LO     0
`define CSS_C0_HSKIND     2
`define CSS_C0_SREMPTY    3
`define CSS_C0_HSDIS      4
`define CSS_C0_DOD        5
`define CSS_C0_EDGE       6
`define CSS_C0_ORDER      7
`define CSS_C1_TXEN       0
`define CSS_C1_TXBE       1
`define CSS_C1_RXEN       2
`define CSS_C1_RXC        3
`define CSS_C1_IRQSEL     4
`define CSS_C1_CONT       5
`define CSS_C1_INV        6
`define CSS_RX_OVR        8
`define CSS_OPT_COD       0
// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define CSS_SYNC_MODE     3'h1
`define CSS_RST_C0        8'h08
`define CSS_RST_C1        8'h02
`define CSS_BITS          4'h8
`define CSS_OVR_BIT       4'h7
`endif

// [pkg/css_pkg.sv]
// Types for the clock synchronous serial channel
package css_pkg;
  typedef enum logic [1:0] {
    CSS_SRC_F1  = 2'h0,
    CSS_SRC_F8  = 2'h1,
    CSS_SRC_F2N = 2'h2
  } css_src_e;
  typedef enum logic [1:0] {
    CSS_IDLE  = 2'h0,
    CSS_FIRST = 2'h1,
    CSS_SHIFT = 2'h2
  } css_state_e;
endpackage : css_pkg

// [core/css_channel.sv]
// Clock synchronous serial channel with register port
`timescale 1ns/1ns
`default_nettype none
`include "css_consts.svh"
module css_channel
  import css_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  input  wire logic [3:0] reg_addr,
  input  wire logic [8:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output var  logic [8:0] reg_rdata,
  input  wire logic       serial_clock_pin_i,
  output var  logic       serial_clock_pin_o,
  output var  logic       serial_clock_pin_oe,
  input  wire logic       serial_in_pin,
  output var  logic       serial_out_pin_o,
  output var  logic       serial_out_pin_oe,
  input  wire logic       clear_to_send_in,
  output var  logic       request_to_send_out,
  output var  logic       tx_irq,
  output var  logic       rx_irq
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] tx_buffer_q, tx_buffer_d, rx_buffer_q, rx_buffer_d;
  logic [7:0] baud_divider_q, baud_divider_d, shift_q, shift_d, rsh_q, rsh_d;
  logic [3:0] mode_q, mode_d, prescale_factor_q, prescale_factor_d;
  logic [7:0] c0_q, c0_d, c1_q, c1_d;
  logic       overrun_flag_q, overrun_flag_d, clock_open_drain_q, clock_open_drain_d;
  logic [7:0] bcnt_q, bcnt_d;
  // Divide-by-2n reloads up to 29, so the prescale counter needs five bits
  logic [4:0] pcnt_q, pcnt_d;
  logic [3:0] bits_q, bits_d;
  logic [2:0] f8cnt_q, f8cnt_d;
  logic       sclk_q, sclk_d, tick_q, tick_d, ext_q, ext_d;
  logic       sout_q, sout_d, soe_q, soe_d, ckoe_q, ckoe_d, rts_q, rts_d;
  logic       txirq_q, txirq_d, rxirq_q, rxirq_d, rdv_q, rdv_d;
  logic [8:0] rdata_q, rdata_d;
  css_state_e st_q, st_d;

  // Helper: pick next bit of a word by order
  function automatic logic css_pick(input logic [7:0] w, input logic msb);
    css_pick = msb ? w[7] : w[0];
  endfunction : css_pick

  // Helper: shift a word by order, inserting a bit
  function automatic logic [7:0] css_shift(input logic [7:0] w, input logic msb,
                                           input logic b);
    css_shift = msb ? {w[6:0], b} : {b, w[7:1]};
  endfunction : css_shift

  wire logic sync_mode = (mode_q[2:0] == `CSS_SYNC_MODE);
  wire logic ext_clk   = mode_q[`CSS_MODE_CLOCK_SOURCE_DIR];
  wire logic edge_sel  = c0_q[`CSS_C0_EDGE];
  wire logic msb_first = c0_q[`CSS_C0_ORDER];
  wire logic invert    = c1_q[`CSS_C1_INV];
  wire logic hs_on     = ~c0_q[`CSS_C0_HSDIS];
  wire logic cts_ok    = ~(hs_on & ~c0_q[`CSS_C0_HSKIND]) | ~clear_to_send_in;

  // ----------------------------------------
  // Baud generation
  // ----------------------------------------
  logic src_en, f2n_en, edge_rise, edge_fall, drv_edge, smp_edge;
  always_comb begin
    f8cnt_d = f8cnt_q + 3'h1;
    pcnt_d  = pcnt_q;
    f2n_en  = 1'b1;
    if (prescale_factor_q != 4'h0) begin
      f2n_en = (pcnt_q == 5'h00);
      pcnt_d = f2n_en ? ({prescale_factor_q, 1'b0} - 5'h01) : pcnt_q - 5'h01;
    end
    case (css_src_e'(c0_q[1:0]))
      CSS_SRC_F1:  src_en = 1'b1;
      CSS_SRC_F8:  src_en = (f8cnt_q == 3'h7);
      CSS_SRC_F2N: src_en = f2n_en;
      default:     src_en = 1'b0;
    endcase
    bcnt_d = bcnt_q;
    tick_d = 1'b0;
    if (src_en) begin
      tick_d = (bcnt_q == 8'h00);
      bcnt_d = tick_d ? baud_divider_q : bcnt_q - 8'h01;
    end
    ext_d = serial_clock_pin_i;
    edge_rise = ext_clk ? (serial_clock_pin_i & ~ext_q) : (tick_q & ~sclk_q);
    edge_fall = ext_clk ? (~serial_clock_pin_i & ext_q) : (tick_q & sclk_q);
    drv_edge  = edge_sel ? edge_rise : edge_fall;
    smp_edge  = edge_sel ? edge_fall : edge_rise;
  end

  // ----------------------------------------
  // Transfer engine and register port
  // ----------------------------------------
  logic start, hit_rd;
  always_comb begin
    // Configuration holds unless software or the transfer engine changes it
    tx_buffer_d = tx_buffer_q;
    rx_buffer_d = rx_buffer_q;
    baud_divider_d = baud_divider_q;
    mode_d = mode_q;
    prescale_factor_d = prescale_factor_q;
    c0_d = c0_q;
    c1_d = c1_q;
    overrun_flag_d = overrun_flag_q;
    clock_open_drain_d = clock_open_drain_q;
    // Engine state holds between transfer clock edges
    shift_d = shift_q;
    rsh_d = rsh_q;
    bits_d = bits_q;
    st_d = st_q;
    sclk_d = sclk_q;
    sout_d = sout_q;
    // Event pulses and read answer last one cycle only
    txirq_d = 1'b0;
    rxirq_d = 1'b0;
    rdv_d = rdv_q;
    rdata_d = 9'h000;
    hit_rd = reg_rd & (reg_addr == `CSS_OFF_RXBUF);
    // Writes from software
    if (reg_wr) begin
      case (reg_addr)
        `CSS_OFF_TXBUF: begin
          tx_buffer_d = reg_wdata[7:0];
          c1_d[`CSS_C1_TXBE] = 1'b0;
        end
        `CSS_OFF_BAUD:  baud_divider_d = reg_wdata[7:0];
        `CSS_OFF_MODE:  mode_d = reg_wdata[3:0];
        `CSS_OFF_CTRL0: c0_d = {reg_wdata[7:4], c0_q[3], reg_wdata[2:0]};
        `CSS_OFF_CTRL1: c1_d = {reg_wdata[7:4], c1_q[3], reg_wdata[2], c1_q[1], reg_wdata[0]};
        `CSS_OFF_PRESC: prescale_factor_d = reg_wdata[3:0];
        `CSS_OFF_OPT:   clock_open_drain_d = reg_wdata[`CSS_OPT_COD];
        default: ;
      endcase
    end
    // Receive buffer read clears complete flag and overrun
    if (hit_rd) begin
      c1_d[`CSS_C1_RXC] = 1'b0;
      overrun_flag_d = 1'b0;
      rdv_d = 1'b0;
      if (c1_q[`CSS_C1_CONT]) c1_d[`CSS_C1_TXBE] = 1'b0;
    end
    start = sync_mode & c1_q[`CSS_C1_TXEN] & ~c1_q[`CSS_C1_TXBE] & cts_ok;
    case (st_q)
      CSS_IDLE: begin
        sclk_d = ~edge_sel;
        sout_d = 1'b1;
        if (start) begin
          shift_d = invert ? ~tx_buffer_q : tx_buffer_q;
          c1_d[`CSS_C1_TXBE] = 1'b1;
          c0_d[`CSS_C0_SREMPTY] = 1'b0;
          txirq_d = ~c1_q[`CSS_C1_IRQSEL];
          bits_d = 4'h0;
          st_d = CSS_FIRST;
        end
      end
      CSS_FIRST, CSS_SHIFT: begin
        if (!ext_clk && tick_q) sclk_d = ~sclk_q;
        if (drv_edge && bits_q != `CSS_BITS) begin
          sout_d = css_pick(shift_q, msb_first);
          shift_d = css_shift(shift_q, msb_first, 1'b1);
          st_d = CSS_SHIFT;
        end
        if (smp_edge && st_q == CSS_SHIFT) begin
          rsh_d = css_shift(rsh_q, msb_first, serial_in_pin ^ invert);
          bits_d = bits_q + 4'h1;
          if (bits_q == `CSS_OVR_BIT - 4'h1 && rdv_q && c1_q[`CSS_C1_RXEN] && !hit_rd)
            overrun_flag_d = 1'b1;
          if (bits_q == `CSS_BITS - 4'h1) begin
            st_d = CSS_IDLE;
            c0_d[`CSS_C0_SREMPTY] = 1'b1;
            txirq_d = c1_q[`CSS_C1_IRQSEL];
            sclk_d = ~edge_sel;
            if (c1_q[`CSS_C1_RXEN]) begin
              rx_buffer_d = css_shift(rsh_q, msb_first, serial_in_pin ^ invert);
              c1_d[`CSS_C1_RXC] = 1'b1;
              rdv_d = 1'b1;
              rxirq_d = ~(overrun_flag_d);
            end
          end
        end
      end
      default: st_d = CSS_IDLE;
    endcase
    // Read data one cycle later
    if (reg_rd) begin
      case (reg_addr)
        `CSS_OFF_TXBUF: rdata_d = {1'b0, tx_buffer_q};
        `CSS_OFF_RXBUF: rdata_d = {overrun_flag_q, rx_buffer_q};
        `CSS_OFF_BAUD:  rdata_d = {1'b0, baud_divider_q};
        `CSS_OFF_MODE:  rdata_d = {5'h00, mode_q};
        `CSS_OFF_CTRL0: rdata_d = {1'b0, c0_q};
        `CSS_OFF_CTRL1: rdata_d = {1'b0, c1_q};
        `CSS_OFF_PRESC: rdata_d = {5'h00, prescale_factor_q};
        `CSS_OFF_OPT:   rdata_d = {8'h00, clock_open_drain_q};
        default:        rdata_d = 9'h000;
      endcase
    end
    // Pin drive
    soe_d  = ~c0_q[`CSS_C0_DOD] | ~sout_d;
    ckoe_d = sync_mode & ~ext_clk & (~clock_open_drain_q | ~sclk_d);
    rts_d  = ~(hs_on & c0_q[`CSS_C0_HSKIND] & c1_q[`CSS_C1_RXEN] & ~c1_q[`CSS_C1_RXC]);
  end

  // Register update
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      // Configuration to its reset values
      tx_buffer_q <= 8'h00;
      rx_buffer_q <= 8'h00;
      baud_divider_q <= 8'h00;
      mode_q <= 4'h0;
      prescale_factor_q <= 4'h0;
      c0_q <= `CSS_RST_C0;
      c1_q <= `CSS_RST_C1;
      overrun_flag_q <= 1'b0;
      clock_open_drain_q <= 1'b0;
      // Engine and dividers idle
      shift_q <= 8'h00;
      rsh_q <= 8'h00;
      bits_q <= 4'h0;
      st_q <= CSS_IDLE;
      bcnt_q <= 8'h00;
      pcnt_q <= 5'h00;
      f8cnt_q <= 3'h0;
      sclk_q <= 1'b1;
      tick_q <= 1'b0;
      ext_q <= 1'b1;
      // Pins at their idle levels, no events
      sout_q <= 1'b1;
      soe_q <= 1'b1;
      ckoe_q <= 1'b0;
      rts_q <= 1'b1;
      txirq_q <= 1'b0;
      rxirq_q <= 1'b0;
      rdv_q <= 1'b0;
      rdata_q <= 9'h000;
    end else begin
      // Configuration
      tx_buffer_q <= tx_buffer_d;
      rx_buffer_q <= rx_buffer_d;
      baud_divider_q <= baud_divider_d;
      mode_q <= mode_d;
      prescale_factor_q <= prescale_factor_d;
      c0_q <= c0_d;
      c1_q <= c1_d;
      overrun_flag_q <= overrun_flag_d;
      clock_open_drain_q <= clock_open_drain_d;
      // Engine and dividers
      shift_q <= shift_d;
      rsh_q <= rsh_d;
      bits_q <= bits_d;
      st_q <= st_d;
      bcnt_q <= bcnt_d;
      pcnt_q <= pcnt_d;
      f8cnt_q <= f8cnt_d;
      sclk_q <= sclk_d;
      tick_q <= tick_d;
      ext_q <= ext_d;
      // Pins, events and read answer
      sout_q <= sout_d;
      soe_q <= soe_d;
      ckoe_q <= ckoe_d;
      rts_q <= rts_d;
      txirq_q <= txirq_d;
      rxirq_q <= rxirq_d;
      rdv_q <= rdv_d;
      rdata_q <= rdata_d;
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata           = rdata_q;
  assign serial_clock_pin_o  = sclk_q;
  assign serial_clock_pin_oe = ckoe_q;
  assign serial_out_pin_o    = sout_q;
  assign serial_out_pin_oe   = soe_q;
  assign request_to_send_out = rts_q;
  assign tx_irq              = txirq_q;
  assign rx_irq              = rxirq_q;
endmodule : css_channel
`default_nettype wire

// [dv/css_peer.sv]
// Clocked serial peer facing the channel
`timescale 1ns/1ns
`default_nettype none
module css_peer (
  input  wire logic       sclk,
  input  wire logic       edge_sel,
  input  wire logic       msb_first,
  input  wire logic       en,
  input  wire logic       din,
  input  wire logic [7:0] tx_word,
  output var  logic       dout,
  output var  logic [7:0] rx_word
);
  int cnt = 0;
  initial dout = 1'b1;
  initial rx_word = 8'h00;
  // Samples on the channel's sampling edge, drives on the other edge
  always @(sclk) begin
    if (!en) begin
      cnt = 0;
      dout = ~dout; // Released line keeps no stale level
    end else if (sclk ^ edge_sel) begin
      rx_word = msb_first ? {rx_word[6:0], din} : {din, rx_word[7:1]};
      cnt = (cnt + 1) % 8;
    end else begin
      dout = tx_word[msb_first ? 7 - cnt : cnt];
    end
  end
endmodule : css_peer
`default_nettype wire

// [dv/css_channel_sva.sv]
// Assertion checker for the serial channel ports
`timescale 1ns/1ns
`default_nettype none
module css_channel_sva (
  input wire logic       clk_sys,
  input wire logic       nrst,
  input wire logic [3:0] reg_addr,
  input wire logic [8:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [8:0] reg_rdata,
  input wire logic       serial_clock_pin_i,
  input wire logic       serial_clock_pin_o,
  input wire logic       serial_clock_pin_oe,
  input wire logic       serial_in_pin,
  input wire logic       serial_out_pin_o,
  input wire logic       serial_out_pin_oe,
  input wire logic       clear_to_send_in,
  input wire logic       request_to_send_out,
  input wire logic       tx_irq,
  input wire logic       rx_irq
);
  logic [15:0] quiet_q;
  logic        pin_q;
  // Cycles since the clock pin last moved, saturating
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      quiet_q <= 16'h0;
      pin_q   <= 1'b1;
    end else begin
      pin_q   <= serial_clock_pin_i;
      quiet_q <= (pin_q != serial_clock_pin_i) ? 16'h0 : quiet_q + {15'h0, quiet_q != 16'hffff};
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  AST_TX_PULSE: assert property (tx_irq |=> !tx_irq)
    else $error("transmit request longer than one cycle");
  AST_RX_PULSE: assert property (rx_irq |=> !rx_irq)
    else $error("receive request longer than one cycle");
  AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 9'h0)
    else $error("read data outside the read answer cycle");
  AST_CLK_OE_CFG: assert property ($changed(serial_clock_pin_oe) |-> $past(reg_wr) || $past(reg_wr, 2))
    else $error("clock pin direction moved without a write");
  AST_CLK_DRIVEN: assert property ($changed(serial_clock_pin_o) && !$past(reg_wr) && !$past(reg_wr, 2) |-> serial_clock_pin_oe)
    else $error("clock toggled while pin is an input");
  AST_RTS_SET: assert property (rx_irq |-> ##[0:2] request_to_send_out)
    else $error("request to send still low after a word");
  AST_RTS_CLR: assert property ($fell(request_to_send_out) |-> $past(reg_wr) || $past(reg_rd) || $past(reg_wr, 2) || $past(reg_rd, 2))
    else $error("request to send fell without an access");
  AST_RX_CLOCKED: assert property (rx_irq |-> quiet_q < 16'd8000)
    else $error("word completed without clock activity");
endmodule : css_channel_sva
bind css_channel css_channel_sva i_css_channel_sva (.clk_sys, .nrst, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .serial_clock_pin_i, .serial_clock_pin_o, .serial_clock_pin_oe, .serial_in_pin,
  .serial_out_pin_o, .serial_out_pin_oe, .clear_to_send_in, .request_to_send_out, .tx_irq, .rx_irq);
`default_nettype wire

// [dv/css_channel_bench.sv]
// Self-checking bench for the serial channel
`timescale 1ns/1ns
`default_nettype none
`include "css_consts.svh"
module css_channel_bench;
  logic       clk_sys = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, ext_clk = 1'b1, cts = 1'b0;
  logic       peer_en = 1'b0, edge_sel = 1'b0, msb = 1'b0, inv, pin, dwire, sin;
  logic       clk_o, clk_oe, out_o, out_oe, rts, tx_irq, rx_irq;
  logic [3:0] reg_addr = 4'h0;
  logic [8:0] reg_wdata = 9'h0, reg_rdata, rd;
  logic [7:0] d, pw = 8'h00, prx;
  int         n_fail = 0, tests_run = 0, n_rx = 0, n_tx = 0, cyc = 0, seed = 39, k, t0;
  always #50 clk_sys = ~clk_sys;
  // Wires resolved from both parties; data line has a pull-up
  assign pin   = clk_oe ? clk_o : ext_clk;
  assign dwire = out_oe ? out_o : 1'b1;
  css_channel i_css_channel (.clk_sys, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .serial_clock_pin_i(pin), .serial_clock_pin_o(clk_o), .serial_clock_pin_oe(clk_oe),
    .serial_in_pin(sin), .serial_out_pin_o(out_o), .serial_out_pin_oe(out_oe),
    .clear_to_send_in(cts), .request_to_send_out(rts), .tx_irq, .rx_irq);
  css_peer i_css_peer (.sclk(pin), .edge_sel, .msb_first(msb), .en(peer_en), .din(dwire),
    .tx_word(pw), .dout(sin), .rx_word(prx));
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run
  // One write or read cycle; read data taken in the answer cycle
  task automatic bus(input logic w, input logic [3:0] a, input logic [8:0] v);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= w;
    reg_rd    <= !w;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge clk_sys);
    rd = reg_rdata;
  endtask : bus
  task automatic wait_ev(input logic rx, input int lim);
    for (k = 0; k < lim && (rx ? rx_irq : tx_irq) !== 1'b1; k++) @(posedge clk_sys);
    chk({8'h0, k < lim}, 9'h1);
  endtask : wait_ev
  task automatic setup(input logic [7:0] c0, input logic [7:0] c1);
    peer_en  <= 1'b0;
    edge_sel <= c0[6];
    msb      <= c0[7];
    inv      = c1[6];
    bus(1'b1, `CSS_OFF_CTRL0, {1'b0, c0});
    bus(1'b1, `CSS_OFF_CTRL1, {1'b0, c1});
    peer_en  <= 1'b1;
    pw       <= 8'($random(seed));
    d        = 8'($random(seed));
  endtask : setup
  // Event counters and hang guard
  always @(posedge clk_sys) begin
    n_rx <= n_rx + int'(rx_irq === 1'b1);
    n_tx <= n_tx + int'(tx_irq === 1'b1);
    cyc  <= cyc + 1;
    if (cyc == 60000) begin
      n_fail++;
      complete_run();
    end
  end
  initial begin
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    chk({7'h0, out_oe, out_o}, 9'h3);
    bus(1'b0, `CSS_OFF_CTRL0, 9'h0);
    chk(rd, {1'b0, `CSS_RST_C0});
    bus(1'b0, `CSS_OFF_CTRL1, 9'h0);
    chk(rd, {1'b0, `CSS_RST_C1});
    bus(1'b1, `CSS_OFF_MODE, {6'h0, `CSS_SYNC_MODE});
    @(posedge clk_sys);
    chk({8'h0, clk_oe}, 9'h1);
    $display("reset test done");
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, `CSS_OFF_BAUD, 9'($random(seed) & 3));
      bus(1'b1, `CSS_OFF_PRESC, 9'($random(seed) & 15 | 1));
      setup({i[1], i[0], 4'h4, 2'(i % 3)}, {1'b0, i[2], 6'h15});
      chk({8'h0, clk_o}, {8'h0, ~edge_sel});
      bus(1'b1, `CSS_OFF_TXBUF, {1'b0, d});
      wait_ev(1'b0, 4000);
      bus(1'b0, `CSS_OFF_RXBUF, 9'h0);
      chk(rd, {1'b0, inv ? ~pw : pw});
      chk({1'b0, prx}, {1'b0, inv ? ~d : d});
      bus(1'b0, `CSS_OFF_CTRL0, 9'h0);
      chk({8'h0, rd[3]}, 9'h1);
    end
    $display("format test done");
    t0 = n_rx;
    bus(1'b1, `CSS_OFF_TXBUF, {1'b0, d});
    wait_ev(1'b0, 1000);
    bus(1'b1, `CSS_OFF_TXBUF, {1'b0, d});
    wait_ev(1'b0, 1000);
    bus(1'b0, `CSS_OFF_RXBUF, 9'h0);
    chk({8'h0, rd[8]}, 9'h1);
    chk(9'(n_rx - t0), 9'h1);
    $display("overrun test done");
    setup(8'h00, 8'h15);
    cts <= 1'b1;
    bus(1'b1, `CSS_OFF_TXBUF, {1'b0, d});
    repeat (30) @(posedge clk_sys);
    bus(1'b0, `CSS_OFF_CTRL0, 9'h0);
    chk({8'h0, rd[3]}, 9'h1);
    cts <= 1'b0;
    wait_ev(1'b0, 400);
    $display("handshake test done");
    setup(8'h10, 8'h35);
    bus(1'b0, `CSS_OFF_RXBUF, 9'h0);
    wait_ev(1'b0, 400);
    bus(1'b0, `CSS_OFF_RXBUF, 9'h0);
    chk({1'b0, rd[7:0]}, {1'b0, pw});
    wait_ev(1'b0, 400);
    $display("continuous test done");
    setup(8'h10, 8'h05);
    bus(1'b0, `CSS_OFF_RXBUF, 9'h0);
    t0 = n_tx;
    bus(1'b1, `CSS_OFF_TXBUF, {1'b0, d});
    repeat (3) @(posedge clk_sys);
    chk(9'(n_tx - t0), 9'h1);
    wait_ev(1'b1, 400);
    chk(9'(n_tx - t0), 9'h1);
    setup(8'h30, 8'h00);
    chk({8'h0, out_oe}, 9'h0);
    $display("interrupt and drive test done");
    bus(1'b1, `CSS_OFF_MODE, 9'h009);
    setup(8'h10, 8'h15);
    chk({8'h0, clk_oe}, 9'h0);
    bus(1'b1, `CSS_OFF_TXBUF, {1'b0, d});
    for (int h = 0; h < 16; h++) begin
      repeat (10) @(posedge clk_sys);
      ext_clk <= ~ext_clk;
    end
    repeat (10) @(posedge clk_sys);
    bus(1'b0, `CSS_OFF_RXBUF, 9'h0);
    chk({1'b0, rd[7:0]}, {1'b0, pw});
    chk({1'b0, prx}, {1'b0, d});
    $display("external clock test done");
    complete_run();
  end
endmodule : css_channel_bench
`default_nettype wire
